// File: watchdog_timer_tb.sv
/*
  Self-checking bench of the watchdog timer: register accesses, restart
  keys, time-out lengths, clock source, responses and the cause flag.
  Assumes the chip reset model and shortened time-out exponents.
*/
`timescale 1ns/1ps
`include "wdtmr_map.svh"

module watchdog_timer_tb;
  localparam int E0 = 6;
  localparam int E1 = 5;
  localparam int E2 = 4;
  localparam int E3 = 3;
  localparam logic [7:0] CTL = `WDTMR_ADDR_CTL;
  localparam logic [7:0] KEY = `WDTMR_ADDR_KEY;
  localparam logic [7:0] STA = `WDTMR_ADDR_STAT;
  localparam logic [7:0] MSK = `WDTMR_ADDR_MASK;

  logic        clk     = 1'b0;
  logic        ext_req = 1'b1;
  logic [7:0]  addr    = 8'h00;
  logic [7:0]  wdata   = 8'h00;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        rtc     = 1'b0;
  logic        i_reset;
  logic        i_nonwdt;
  logic [7:0]  rdata;
  logic        wdt_rst;
  logic        nmi;
  logic        irq;
  logic [7:0]  v;
  int          n;
  int          nmi_cnt    = 0;
  int          nmi_base   = 0;
  int          rtc_div    = 0;
  int          fail_count = 0;
  int          checked    = 0;
  int          exps[4]    = '{E0, E1, E2, E3};

  always #10 clk = ~clk;

  // slow source: one rising edge every 8 system cycles
  always @(posedge clk) begin
    rtc_div <= rtc_div + 1;
    if (rtc_div % 4 == 3) rtc <= ~rtc;
    if (nmi === 1'b1) nmi_cnt <= nmi_cnt + 1;
  end

  wdtmr_rst_model #(.P_HOLD(4)) u_rst (
    .i_clk     (clk),
    .i_ext_req (ext_req),
    .i_wdt_req (wdt_rst),
    .o_reset   (i_reset),
    .o_nonwdt  (i_nonwdt)
  );

  wdtmr_top #(
    .P_TOUT_EXP_0 (E0),
    .P_TOUT_EXP_1 (E1),
    .P_TOUT_EXP_2 (E2),
    .P_TOUT_EXP_3 (E3)
  ) DUT (
    .I_CLK_SYS      (clk),
    .I_RESET        (i_reset),
    .I_NONWDT_RESET (i_nonwdt),
    .I_ADDR         (addr),
    .I_WDATA        (wdata),
    .I_WR           (wr),
    .I_RD           (rd),
    .O_RDATA        (rdata),
    .I_RTC_CLK      (rtc),
    .O_WDT_RESET    (wdt_rst),
    .O_NMI          (nmi),
    .O_IRQ          (irq)
  );

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic keys();
    wr_reg(KEY, `WDTMR_KEY_FIRST);
    wr_reg(KEY, `WDTMR_KEY_SECOND);
  endtask

  // cycles until the chosen response shows, bound when it never does
  task automatic wait_sig(input bit pick_rst, input int bound, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      #1 cnt++;
    end while (cnt < bound && ((pick_rst ? wdt_rst : nmi) !== 1'b1));
  endtask

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end

  initial begin
    repeat (20) @(posedge clk);
    ext_req <= 1'b0;
    repeat (3) @(posedge clk);
    rd_reg(CTL, v); chk("ctl after reset", v, 8'h00);
    wr_reg(KEY, 8'h3c);
    rd_reg(KEY, v); chk("restart reg read", v, 8'h00);
    rd_reg(8'h10, v); chk("unmapped read", v, 8'h00);
    wr_reg(CTL, 8'h7f);
    rd_reg(CTL, v); chk("ctl fields", v, 8'h5b);
    // enable, nmi response, longest period
    wr_reg(CTL, 8'hc0);
    wait_sig(0, 100, n);
    chk("first timeout", {7'h0, n >= 62 && n <= 70}, 8'h01);
    rd_reg(CTL, v); chk("cause flag on nmi", v, 8'he0);
    chk("irq masked", {7'h0, irq}, 8'h00);
    rd_reg(STA, v); chk("status set", v, 8'h01);
    wr_reg(MSK, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq unmasked", {7'h0, irq}, 8'h01);
    wr_reg(STA, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq cleared", {7'h0, irq}, 8'h00);
    rd_reg(STA, v); chk("status cleared", v, 8'h00);
    wr_reg(CTL, 8'h40);
    rd_reg(CTL, v); chk("enable sticks", v, 8'he0);
    for (int p = 0; p < 4; p++) begin
      wr_reg(CTL, 8'hc0 | 8'(p));
      keys();
      wait_sig(0, 200, n);
      chk("period length", {7'h0, n >= 2**exps[p] && n <= 2**exps[p] + 4}, 8'h01);
    end
    wr_reg(CTL, 8'hc0);
    keys();
    repeat (40) @(posedge clk);
    wr_reg(KEY, `WDTMR_KEY_FIRST);
    wr_reg(KEY, 8'h11);
    wr_reg(KEY, `WDTMR_KEY_SECOND);
    wait_sig(0, 100, n);
    chk("broken sequence", {7'h0, n < 30}, 8'h01);
    repeat (40) @(posedge clk);
    wr_reg(KEY, `WDTMR_KEY_FIRST);
    repeat (10) @(posedge clk);
    wr_reg(KEY, `WDTMR_KEY_SECOND);
    wait_sig(0, 100, n);
    chk("delayed second key", {7'h0, n >= 64 && n <= 68}, 8'h01);
    // slow clock source, eight ticks of eight cycles
    wr_reg(CTL, 8'hc3);
    wait_sig(0, 40, n);
    wr_reg(CTL, 8'hcb);
    keys();
    wait_sig(0, 200, n);
    chk("slow source", {7'h0, n >= 56 && n <= 76}, 8'h01);
    wr_reg(CTL, 8'hd3);
    keys();
    wait_sig(0, 120, n);
    chk("reserved source", {7'h0, n == 120}, 8'h01);
    // reset response
    nmi_base = nmi_cnt;
    wr_reg(CTL, 8'h83);
    wait_sig(1, 40, n);
    chk("reset response", {7'h0, n < 40}, 8'h01);
    repeat (10) @(posedge clk);
    chk("no nmi on reset", {7'h0, nmi_cnt == nmi_base}, 8'h01);
    chk("reset request off", {7'h0, wdt_rst}, 8'h00);
    rd_reg(CTL, v); chk("flag survives", v, 8'h20);
    @(posedge clk);
    ext_req <= 1'b1;
    repeat (3) @(posedge clk);
    ext_req <= 1'b0;
    repeat (3) @(posedge clk);
    rd_reg(CTL, v); chk("flag cleared", v, 8'h00);
    report_and_stop();
  end
endmodule

// File: wdtmr_cnt_if.sv
/*
  Interface between the watchdog control logic and its time-out counter.
  Assumes both ends run on the system clock.
*/
`timescale 1ns/1ps
`include "wdtmr_map.svh"

interface wdtmr_cnt_if;
  logic                     run;
  logic                     tick;
  logic                     reload;
  logic [`WDTMR_CNT_W-1:0]  limit;
  logic                     tout;
  logic [`WDTMR_CNT_W-1:0]  count;

  modport ctl (output run, output tick, output reload, output limit,
               input tout, input count);
  modport cnt (input run, input tick, input reload, input limit,
               output tout, output count);
endinterface

// File: wdtmr_counter.sv
/*
  Time-out counter of the watchdog: counts ticks up to a terminal value.
  Assumes run, tick, reload and limit come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "wdtmr_map.svh"

module wdtmr_counter (
  // clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_rst,
  // control side
  wdtmr_cnt_if.cnt   cif
);

  logic [`WDTMR_CNT_W-1:0] count_q;
  logic                    at_end;

  // terminal on or past limit, so a lowered limit cannot wrap the count
  assign at_end     = (count_q >= cif.limit);
  assign cif.tout   = !i_rst && cif.run && cif.tick && at_end && !cif.reload; // [R8]
  assign cif.count  = count_q;

  always_ff @(posedge i_clk) begin
    if (i_rst || !cif.run) begin
      count_q <= '0;
    end else if (cif.reload) begin
      count_q <= '0; // [R10]
    end else if (cif.tick) begin
      count_q <= at_end ? '0 : count_q + `WDTMR_CNT_W'(1); // [R8]
    end
  end

  tout_wrap_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R8]
    cif.tout |-> count_q == cif.limit ##1 count_q == '0)
    else $error("time-out not at the terminal count");

  count_step_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R8]
    cif.run && cif.tick && !cif.reload && !at_end |=> count_q == $past(count_q) + 1)
    else $error("counter did not advance on a tick");

endmodule

// File: wdtmr_map.svh
/*
  Register offsets, field positions, reset values and time-out exponents
  of the watchdog timer.
  Assumes an 8-bit register port with byte offsets as listed here.
*/
`ifndef WDTMR_MAP_SVH
`define WDTMR_MAP_SVH

// register offsets
`define WDTMR_ADDR_CTL      8'h93
`define WDTMR_ADDR_KEY      8'h94
`define WDTMR_ADDR_STAT     8'h95
`define WDTMR_ADDR_MASK     8'h96

// control field positions
`define WDTMR_CTL_EN        7
`define WDTMR_CTL_NMI       6
`define WDTMR_CTL_FLAG      5
`define WDTMR_CTL_CLK_HI    4
`define WDTMR_CTL_CLK_LO    3
`define WDTMR_CTL_RSVD      2
`define WDTMR_CTL_PER_HI    1
`define WDTMR_CTL_PER_LO    0

// interrupt status and mask positions
`define WDTMR_STAT_TOUT     0

// restart keys
`define WDTMR_KEY_FIRST     8'ha5
`define WDTMR_KEY_SECOND    8'h5a

// reset values
`define WDTMR_RST_CLK       2'h0
`define WDTMR_RST_PER       2'h0
`define WDTMR_RST_STAT      1'h0
`define WDTMR_RST_MASK      1'h0

// counter width and time-out exponents per period code
`define WDTMR_CNT_W         27
`define WDTMR_TOUT_EXP_0    27
`define WDTMR_TOUT_EXP_1    25
`define WDTMR_TOUT_EXP_2    22
`define WDTMR_TOUT_EXP_3    18

`endif

// File: wdtmr_pkg.sv
/*
  Types of the watchdog timer: counter clock codes and key sequence states.
  Assumes nothing of its surroundings.
*/
package wdtmr_pkg;

  typedef enum logic [1:0] {
    WDTMR_CLK_SYS   = 2'h0,
    WDTMR_CLK_RTC   = 2'h1,
    WDTMR_CLK_RSV2  = 2'h2,
    WDTMR_CLK_RSV3  = 2'h3
  } wdtmr_clksel_t;

  typedef enum logic [1:0] {
    WDTMR_KEY_IDLE  = 2'b01,
    WDTMR_KEY_ARMED = 2'b10
  } wdtmr_key_t;

endpackage

// File: wdtmr_rst_model.sv
/*
  Chip reset logic model facing the watchdog: turns an external reset
  request or the watchdog reset request into the system reset.
  Assumes the watchdog reset request is a level held until reset is seen.
*/
`timescale 1ns/1ps

module wdtmr_rst_model #(
  parameter int P_HOLD = 4
) (
  // clock
  input  wire logic  i_clk,
  // reset requests
  input  wire logic  i_ext_req,
  input  wire logic  i_wdt_req,
  // system reset out
  output logic       o_reset,
  output logic       o_nonwdt
);
  int hold_q = 0;

  initial begin
    o_reset  = 1'b1;
    o_nonwdt = 1'b1;
  end

  always @(posedge i_clk) begin
    if (i_ext_req) begin
      o_reset  <= 1'b1;
      o_nonwdt <= 1'b1;
    end else if (i_wdt_req && hold_q == 0) begin
      hold_q   <= P_HOLD;
      o_reset  <= 1'b1;
      o_nonwdt <= 1'b0;
    end else if (hold_q > 1) begin
      hold_q <= hold_q - 1;
    end else begin
      hold_q  <= 0;
      o_reset <= 1'b0;
    end
  end
endmodule

// File: wdtmr_top.sv
/*
  Watchdog timer: control and restart-key registers, clock source choice,
  time-out response as chip reset request or NMI, cause flag, interrupt.
  Assumes an 8-bit register port on the system clock, a chip reset logic
  that answers the reset request with I_RESET and marks non-watchdog
  resets on I_NONWDT_RESET, and an RTC source arriving asynchronously.
*/
// Design decision made here: the plain strobed port.
// How it works
// R1: the control register is 8 bits, read and write except the reserved and cause bits.
// R2: bit 7 enables the watchdog and only a chip reset can clear it once set.
// R3: bit 6 picks the time-out response, 0 for a chip reset request and 1 for an NMI.
// R4: read-only bit 5 is set by every time-out whatever the response.
// R5: the cause flag survives a watchdog reset and is cleared only by another reset.
// R6: after an external or debug interface reset the cause flag reads 0.
// R7: field 4:3 picks the counter clock, 00 system clock, 01 RTC source, others reserved.
// R8: field 1:0 sets the time-out to 2^27, 2^25, 2^22 or 2^18 selected clock cycles.
// R9: the restart register is write-only and stores nothing readable.
// R10: writing A5h then 5Ah reloads the counter to its initial count and counting goes on.
// R11: any delay is allowed between the two keys as long as no time-out comes first.
// R12: after reset the watchdog is off and its response is a chip reset.
// R13: a restart write that does not continue the sequence drops a half-entered sequence.
// R14: reserved control bit 2 always reads 0 and ignores writes.
`timescale 1ns/1ps
`include "wdtmr_map.svh"

module wdtmr_top #(
  parameter int P_TOUT_EXP_0 = `WDTMR_TOUT_EXP_0,
  parameter int P_TOUT_EXP_1 = `WDTMR_TOUT_EXP_1,
  parameter int P_TOUT_EXP_2 = `WDTMR_TOUT_EXP_2,
  parameter int P_TOUT_EXP_3 = `WDTMR_TOUT_EXP_3
) (
  // clock and reset
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RESET,
  input  wire logic        I_NONWDT_RESET,
  // register port
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [7:0]  O_RDATA,
  // clock source
  input  wire logic        I_RTC_CLK,
  // time-out responses
  output logic             O_WDT_RESET,
  output logic             O_NMI,
  output logic             O_IRQ
);

  localparam int CW = `WDTMR_CNT_W;

  // control state
  logic                   watchdog_enable_q;
  logic                   nmi_select_q;
  logic                   cause_flag_q;
  wdtmr_pkg::wdtmr_clksel_t counter_clock_select_q;
  logic [1:0]             timeout_length_select_q;

  // key sequence
  wdtmr_pkg::wdtmr_key_t  key_state_q;
  logic                   reload_q;

  // rtc source synchroniser and edge detect
  logic                   rtc_s1_q;
  logic                   rtc_s2_q;
  logic                   rtc_s3_q;
  logic                   rtc_rise;

  // interrupt registers
  logic                   irq_stat_q;
  logic                   irq_mask_q;

  // decoded accesses
  logic                   wr_ctl;
  logic                   wr_key;
  logic                   wr_stat;
  logic                   wr_mask;
  logic                   rd_ctl;
  logic                   rd_key;
  logic                   tout;
  logic [7:0]             ctl_view;

  wdtmr_cnt_if cif ();

  // terminal count for a period code
  function automatic logic [CW-1:0] tout_limit(input logic [1:0] sel);
    int exp_v;
    exp_v = P_TOUT_EXP_0;
    unique case (sel)
      2'h0: exp_v = P_TOUT_EXP_0;
      2'h1: exp_v = P_TOUT_EXP_1;
      2'h2: exp_v = P_TOUT_EXP_2;
      2'h3: exp_v = P_TOUT_EXP_3;
    endcase
    return CW'((64'd1 << exp_v) - 64'd1);
  endfunction

  assign wr_ctl  = I_WR && (I_ADDR == `WDTMR_ADDR_CTL);
  assign wr_key  = I_WR && (I_ADDR == `WDTMR_ADDR_KEY);
  assign wr_stat = I_WR && (I_ADDR == `WDTMR_ADDR_STAT);
  assign wr_mask = I_WR && (I_ADDR == `WDTMR_ADDR_MASK);
  assign rd_ctl  = I_RD && (I_ADDR == `WDTMR_ADDR_CTL);
  assign rd_key  = I_RD && (I_ADDR == `WDTMR_ADDR_KEY);
  assign tout    = cif.tout;

  // control register read view, reserved bit fixed low
  assign ctl_view = {watchdog_enable_q, nmi_select_q, cause_flag_q,
                     counter_clock_select_q, 1'b0, timeout_length_select_q}; // [R1] [R14]

  // enable: set by software, cleared by reset only
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      watchdog_enable_q <= 1'b0; // [R12]
    end else if (wr_ctl && I_WDATA[`WDTMR_CTL_EN]) begin
      watchdog_enable_q <= 1'b1; // [R2]
    end
  end

  // writable configuration fields; bits 5 and 2 are not stored
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      nmi_select_q            <= 1'b0; // [R12]
      counter_clock_select_q  <= wdtmr_pkg::wdtmr_clksel_t'(`WDTMR_RST_CLK);
      timeout_length_select_q <= `WDTMR_RST_PER;
    end else if (wr_ctl) begin
      nmi_select_q            <= I_WDATA[`WDTMR_CTL_NMI]; // [R3]
      counter_clock_select_q  <= wdtmr_pkg::wdtmr_clksel_t'(
                                   I_WDATA[`WDTMR_CTL_CLK_HI:`WDTMR_CTL_CLK_LO]); // [R7]
      timeout_length_select_q <= I_WDATA[`WDTMR_CTL_PER_HI:`WDTMR_CTL_PER_LO]; // [R8]
    end
  end

  // cause flag: only a non-watchdog reset clears it
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET && I_NONWDT_RESET) begin
      cause_flag_q <= 1'b0; // [R5] [R6]
    end else if (tout) begin
      cause_flag_q <= 1'b1; // [R4]
    end
  end

  // rtc source: three flops, rising edge from the last two
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      rtc_s1_q <= 1'b0;
      rtc_s2_q <= 1'b0;
      rtc_s3_q <= 1'b0;
    end else begin
      rtc_s1_q <= I_RTC_CLK;
      rtc_s2_q <= rtc_s1_q;
      rtc_s3_q <= rtc_s2_q;
    end
  end

  assign rtc_rise = rtc_s2_q && !rtc_s3_q;

  // counter tick by source; reserved codes give no ticks
  always_comb begin
    cif.tick = 1'b0;
    unique case (counter_clock_select_q)
      wdtmr_pkg::WDTMR_CLK_SYS:  cif.tick = 1'b1; // [R7]
      wdtmr_pkg::WDTMR_CLK_RTC:  cif.tick = rtc_rise; // [R7]
      wdtmr_pkg::WDTMR_CLK_RSV2: cif.tick = 1'b0;
      wdtmr_pkg::WDTMR_CLK_RSV3: cif.tick = 1'b0;
    endcase
  end

  assign cif.run    = watchdog_enable_q;
  assign cif.limit  = tout_limit(timeout_length_select_q); // [R8]
  assign cif.reload = reload_q;

  // restart key sequence
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      key_state_q <= wdtmr_pkg::WDTMR_KEY_IDLE;
      reload_q    <= 1'b0;
    end else begin
      reload_q <= 1'b0;
      if (wr_key) begin
        unique case (key_state_q)
          wdtmr_pkg::WDTMR_KEY_IDLE: begin
            if (I_WDATA == `WDTMR_KEY_FIRST) begin
              key_state_q <= wdtmr_pkg::WDTMR_KEY_ARMED;
            end
          end
          wdtmr_pkg::WDTMR_KEY_ARMED: begin
            if (I_WDATA == `WDTMR_KEY_SECOND) begin
              key_state_q <= wdtmr_pkg::WDTMR_KEY_IDLE;
              reload_q    <= 1'b1; // [R10]
            end else if (I_WDATA != `WDTMR_KEY_FIRST) begin
              key_state_q <= wdtmr_pkg::WDTMR_KEY_IDLE; // [R13]
            end
          end
          default: key_state_q <= wdtmr_pkg::WDTMR_KEY_IDLE;
        endcase
      end
    end
  end

  wdtmr_counter u_counter (
    .i_clk (I_CLK_SYS),
    .i_rst (I_RESET),
    .cif   (cif)
  );

  // reset request held until the chip reset arrives
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      O_WDT_RESET <= 1'b0;
    end else if (tout && !nmi_select_q) begin
      O_WDT_RESET <= 1'b1; // [R3]
    end
  end

  // nmi as a one-cycle pulse per time-out
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      O_NMI <= 1'b0;
    end else begin
      O_NMI <= tout && nmi_select_q; // [R3]
    end
  end

  // interrupt status, set wins over write-one-to-clear
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      irq_stat_q <= `WDTMR_RST_STAT;
    end else begin
      irq_stat_q <= (irq_stat_q && !(wr_stat && I_WDATA[`WDTMR_STAT_TOUT])) || tout;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      irq_mask_q <= `WDTMR_RST_MASK;
    end else if (wr_mask) begin
      irq_mask_q <= I_WDATA[`WDTMR_STAT_TOUT];
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= irq_stat_q && irq_mask_q;
    end
  end

  // read data in the cycle after the strobe only
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      O_RDATA <= 8'h00;
    end else if (I_RD) begin
      unique case (I_ADDR)
        `WDTMR_ADDR_CTL:  O_RDATA <= ctl_view; // [R1]
        `WDTMR_ADDR_KEY:  O_RDATA <= 8'h00; // [R9]
        `WDTMR_ADDR_STAT: O_RDATA <= {7'h00, irq_stat_q};
        `WDTMR_ADDR_MASK: O_RDATA <= {7'h00, irq_mask_q};
        default:          O_RDATA <= 8'h00;
      endcase
    end else begin
      O_RDATA <= 8'h00;
    end
  end

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);

  enable_sticky_a: assert property ( // [R2]
    watchdog_enable_q |=> watchdog_enable_q)
    else $error("watchdog enable dropped without reset");

  reset_default_a: assert property ( // [R12]
    $fell(I_RESET) |-> !watchdog_enable_q && !nmi_select_q && !O_WDT_RESET)
    else $error("watchdog not off with reset response after reset");

  ctl_readback_a: assert property ( // [R1]
    rd_ctl |=> O_RDATA == $past(ctl_view) && O_RDATA[`WDTMR_CTL_RSVD] == 1'b0)
    else $error("control read does not match the stored fields");

  rsvd_ignore_a: assert property ( // [R14]
    wr_ctl ##2 rd_ctl |=> O_RDATA[`WDTMR_CTL_RSVD] == 1'b0)
    else $error("reserved control bit read back high");

  key_writeonly_a: assert property ( // [R9]
    rd_key |=> O_RDATA == 8'h00)
    else $error("restart register read returned data");

  flag_on_tout_a: assert property ( // [R4]
    tout |=> cause_flag_q ##1 cause_flag_q || I_RESET)
    else $error("cause flag not set by time-out");

  flag_survive_a: assert property (@(posedge I_CLK_SYS) disable iff (1'b0) // [R5]
    I_RESET && !I_NONWDT_RESET && cause_flag_q |=> cause_flag_q)
    else $error("cause flag lost across a watchdog reset");

  flag_clear_a: assert property ( // [R6]
    $fell(I_RESET) && $past(I_NONWDT_RESET) |-> !cause_flag_q)
    else $error("cause flag not cleared by a non-watchdog reset");

  reset_resp_a: assert property ( // [R3]
    tout && !nmi_select_q |=> O_WDT_RESET && !O_NMI)
    else $error("reset response missing or nmi raised");

  nmi_resp_a: assert property ( // [R3]
    tout && nmi_select_q |=> O_NMI ##1 !O_NMI)
    else $error("nmi response not a single pulse");

  sys_tick_a: assert property ( // [R7]
    counter_clock_select_q == wdtmr_pkg::WDTMR_CLK_SYS && cif.run && !cif.reload
    |=> cif.count != $past(cif.count))
    else $error("system clock source does not tick each cycle");

  key_reload_a: assert property ( // [R10]
    wr_key && I_WDATA == `WDTMR_KEY_SECOND && key_state_q == wdtmr_pkg::WDTMR_KEY_ARMED
    |=> ##1 cif.count == '0)
    else $error("key pair did not reload the counter");

  key_wait_a: assert property ( // [R11]
    key_state_q == wdtmr_pkg::WDTMR_KEY_ARMED && !wr_key |=>
      key_state_q == wdtmr_pkg::WDTMR_KEY_ARMED)
    else $error("armed key state lost without a restart write");

  key_discard_a: assert property ( // [R13]
    wr_key && I_WDATA != `WDTMR_KEY_FIRST |=> key_state_q == wdtmr_pkg::WDTMR_KEY_IDLE)
    else $error("partial key sequence not discarded");

  key_arm_a: assert property ( // [R10]
    wr_key && I_WDATA == `WDTMR_KEY_FIRST |=> key_state_q == wdtmr_pkg::WDTMR_KEY_ARMED)
    else $error("first key did not arm the sequence");

  enable_set_a: assert property ( // [R2]
    wr_ctl && I_WDATA[`WDTMR_CTL_EN] |=> watchdog_enable_q)
    else $error("enable write not taken");

  cfg_write_a: assert property ( // [R3] [R8]
    wr_ctl |=> nmi_select_q == $past(I_WDATA[`WDTMR_CTL_NMI]) &&
      timeout_length_select_q == $past(I_WDATA[`WDTMR_CTL_PER_HI:`WDTMR_CTL_PER_LO]))
    else $error("control write not stored");

  rdata_idle_a: assert property ( // [R1]
    !I_RD |=> O_RDATA == 8'h00)
    else $error("read data shown without a read");

  rsvd_clock_a: assert property ( // [R7]
    counter_clock_select_q inside {wdtmr_pkg::WDTMR_CLK_RSV2, wdtmr_pkg::WDTMR_CLK_RSV3}
    && !cif.reload |=> $stable(cif.count))
    else $error("reserved clock source moved the counter");

  resp_hold_a: assert property ( // [R3]
    O_WDT_RESET |=> O_WDT_RESET)
    else $error("reset request dropped before reset");

  nmi_cause_a: assert property ( // [R3]
    O_NMI |-> $past(tout && nmi_select_q))
    else $error("nmi without a time-out in nmi response");

  stat_set_a: assert property (
    tout |=> irq_stat_q)
    else $error("status bit not set by time-out");

endmodule
